// ---- core/uspi_link.sv ----
// transceiver operated in spi mode, master or slave by mode code
// assumes software pulses soft_reset after changing role; slave clock is link_clk_in
// Notes on behaviour
// - mode 0xE master, 0xF slave
// - full duplex shifting in both roles
// - only one slave select output
// - mosi on txd master, rxd slave
// - miso on rxd master, txd slave
// - master clocks one period per bit
// - select on rts master, cts slave
`timescale 1ns/1ps
`include "uspi_defs.svh"
module uspi_link #(
	parameter logic [15:0] DIV = `USPI_DIV_DEF
)(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic soft_reset_in,
	input wire logic [`USPI_MODE_W-1:0] channel_operating_select_in,
	input wire logic tx_valid_in,
	input wire logic [`USPI_DATA_W-1:0] tx_data_in,
	output logic tx_ready_out,
	output logic rx_valid_out,
	output logic [`USPI_DATA_W-1:0] rx_data_out,
	input wire logic link_clk_in,
	input wire logic rxd_in,
	input wire logic cts_in,
	output logic txd_out,
	output logic txd_oe_out,
	output logic clk_out,
	output logic clk_oe_out,
	output logic rts_out
);
	// two-flop release of the external reset
	logic [1:0] rst_sync_reg;
	logic rst_n;
	// role, latched only at soft reset
	logic [`USPI_MODE_W-1:0] mode_reg;
	logic is_master;
	logic is_slave;
	// master engine registers and their next values
	uspi_pkg::uspi_state_e st_reg;
	uspi_pkg::uspi_state_e st_next;
	logic [15:0] div_reg;
	logic [15:0] div_next;
	logic [`USPI_CNT_W-1:0] bit_reg;
	logic [`USPI_CNT_W-1:0] bit_next;
	logic [`USPI_DATA_W-1:0] msh_reg;
	logic [`USPI_DATA_W-1:0] msh_next;
	logic sck_reg;
	logic sck_next;
	logic cap_reg;
	logic cap_next;
	// pin synchronisers into the system clock
	logic [2:0] rxd_sync_reg;
	logic [2:0] cts_sync_reg;
	logic rxd_s;
	logic cts_s;
	// slave engine on the link clock
	logic [`USPI_DATA_W-1:0] ssh_reg;
	logic [`USPI_DATA_W-1:0] ssh_next;
	logic [`USPI_DATA_W-1:0] sload_reg;
	logic [2:0] scnt_reg;
	logic stog_reg;
	logic smiso_reg;
	logic slave_last;
	// word hand-over back into the system clock
	logic [2:0] tog_sync_reg;
	logic s_done;
	// request carrier and next values of the registered outputs
	uspi_pkg::uspi_word_s tx_req;
	logic rx_valid_next;
	logic [`USPI_DATA_W-1:0] rx_data_next;
	logic tx_ready_next;
	logic txd_next;
	logic txd_oe_next;
	logic clk_oe_next;
	logic rts_next;

	// one bit enters at the low end, so the msb leaves first
	function automatic logic [`USPI_DATA_W-1:0] shift_word(
		input logic [`USPI_DATA_W-1:0] word,
		input logic bit_val
	);
		shift_word = {word[`USPI_DATA_W-2:0], bit_val};
	endfunction : shift_word

	// role decode, shared by both roles
	function automatic logic mode_is(
		input logic [`USPI_MODE_W-1:0] mode,
		input logic [`USPI_MODE_W-1:0] code
	);
		mode_is = (mode == code);
	endfunction : mode_is

	// reset release through two flops
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in) rst_sync_reg <= 2'h0;
		else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// mode latched only on soft reset so a role change takes effect cleanly
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n) mode_reg <= `USPI_MODE_NONE;
		else if (soft_reset_in) mode_reg <= channel_operating_select_in;
	end
	assign is_master = mode_is(mode_reg, `USPI_MODE_MASTER);
	assign is_slave = mode_is(mode_reg, `USPI_MODE_SLAVE);

	// pins pass three flops; only the third is read, on every system clock
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n) rxd_sync_reg <= 3'h0;
		else rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_in};
	end
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n) cts_sync_reg <= 3'h0;
		else cts_sync_reg <= {cts_sync_reg[1:0], cts_in};
	end
	assign rxd_s = rxd_sync_reg[2];
	assign cts_s = cts_sync_reg[2];

	// master decode; the divider clock comes from this domain
	assign tx_req = {tx_valid_in, tx_data_in};
	wire in_idle = (st_reg == uspi_pkg::USPI_IDLE);
	wire in_shift = (st_reg == uspi_pkg::USPI_SHIFT);
	wire in_done = (st_reg == uspi_pkg::USPI_DONE);
	wire tick = in_shift && (div_reg == DIV - 16'h0001);
	wire rise_tick = tick && !sck_reg;
	wire fall_tick = tick && sck_reg;
	wire last_bit = (bit_reg == `USPI_LAST_BIT);
	// a request counts only while ready is shown, so none is taken in slave role
	wire take = is_master && in_idle && tx_ready_out && tx_req.valid;

	// master sequencing: idle, eight clock periods, one done cycle
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			uspi_pkg::USPI_IDLE:
			begin
				if (take) st_next = uspi_pkg::USPI_SHIFT;
			end
			uspi_pkg::USPI_SHIFT:
			begin
				if (fall_tick && last_bit) st_next = uspi_pkg::USPI_DONE;
			end
			uspi_pkg::USPI_DONE: st_next = uspi_pkg::USPI_IDLE;
			default: st_next = uspi_pkg::USPI_IDLE;
		endcase
	end

	// sample on the rising half, shift on the falling half, so mosi never
	// moves while the far slave samples it
	assign div_next = (!in_shift || tick) ? 16'h0000 : div_reg + 16'h0001;
	assign sck_next = tick ? ~sck_reg : sck_reg;
	assign cap_next = rise_tick ? rxd_s : cap_reg; // miso on rxd
	assign msh_next = take ? tx_req.data : (fall_tick ? shift_word(msh_reg, cap_reg) : msh_reg);
	assign bit_next = take ? 4'h0 : ((fall_tick && !last_bit) ? bit_reg + 4'h1 : bit_reg);

	// state and divider; soft reset aborts any master transfer in flight, the slave engine ignores it
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= uspi_pkg::USPI_IDLE;
			div_reg <= 16'h0000;
		end
		else if (soft_reset_in)
		begin
			st_reg <= uspi_pkg::USPI_IDLE;
			div_reg <= 16'h0000;
		end
		else
		begin
			st_reg <= st_next;
			div_reg <= div_next;
		end
	end

	// bit counter, serial clock and captured miso bit
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_reg <= 4'h0;
			sck_reg <= 1'b0;
			cap_reg <= 1'b0;
		end
		else if (soft_reset_in)
		begin
			bit_reg <= 4'h0;
			sck_reg <= 1'b0;
			cap_reg <= 1'b0;
		end
		else
		begin
			bit_reg <= bit_next;
			sck_reg <= sck_next;
			cap_reg <= cap_next;
		end
	end

	// master shift register: outgoing byte in, received byte out
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n) msh_reg <= 8'h00;
		else if (soft_reset_in) msh_reg <= 8'h00;
		else msh_reg <= msh_next;
	end

	// slave engine on the link clock
	// select is launched by the far master in step with this clock, so it
	// needs no synchroniser here; the reset is released while the clock is
	// stopped, which a link clock that only runs in frames makes safe
	assign ssh_next = shift_word(ssh_reg, rxd_in); // mosi on rxd
	assign slave_last = (scnt_reg == `USPI_SLAVE_LAST);
	always_ff @(posedge link_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssh_reg <= 8'h00;
			scnt_reg <= 3'h0;
		end
		else if (cts_in) // select high marks this slave chosen
		begin
			ssh_reg <= ssh_next;
			scnt_reg <= scnt_reg + 3'h1;
		end
		else scnt_reg <= 3'h0;
	end

	// finished word held for eight link clocks while the toggle crosses
	always_ff @(posedge link_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sload_reg <= 8'h00;
			stog_reg <= 1'b0;
		end
		else if (cts_in && slave_last)
		begin
			sload_reg <= ssh_next;
			stog_reg <= ~stog_reg;
		end
	end

	// slave miso driven on falling link edge from shift register
	always_ff @(negedge link_clk_in or negedge rst_n)
	begin
		if (!rst_n) smiso_reg <= 1'b0;
		else smiso_reg <= ssh_reg[`USPI_DATA_W-1];
	end

	// toggle crosses through three flops; only the third and second are compared
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n) tog_sync_reg <= 3'h0;
		else tog_sync_reg <= {tog_sync_reg[1:0], stog_reg};
	end
	assign s_done = is_slave && (tog_sync_reg[2] != tog_sync_reg[1]);

	// output next values; select rises with the take so the far slave's
	// miso has passed the synchroniser before the first sample (needs DIV of 4)
	assign rx_valid_next = in_done || s_done;
	assign rx_data_next = s_done ? sload_reg : msh_reg;
	assign tx_ready_next = is_master && in_idle && !take;
	assign txd_next = is_master ? msh_reg[`USPI_DATA_W-1] : smiso_reg;
	assign txd_oe_next = is_master || (is_slave && cts_s);
	assign clk_oe_next = is_master;
	assign rts_next = is_master && (in_shift || take); // single select

	// outputs, all registered
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_valid_out <= 1'b0;
			rx_data_out <= 8'h00;
			tx_ready_out <= 1'b0;
			txd_out <= 1'b0;
			txd_oe_out <= 1'b0;
			clk_out <= 1'b0;
			clk_oe_out <= 1'b0;
			rts_out <= 1'b0;
		end
		else
		begin
			rx_valid_out <= rx_valid_next;
			rx_data_out <= rx_data_next;
			tx_ready_out <= tx_ready_next;
			txd_out <= txd_next;
			txd_oe_out <= txd_oe_next;
			clk_out <= sck_reg;
			clk_oe_out <= clk_oe_next;
			rts_out <= rts_next;
		end
	end
endmodule : uspi_link

// ---- pkg/uspi_defs.svh ----
// constants for the transceiver spi-mode link
// assumes inclusion by bare name from the design file
`ifndef USPI_DEFS_SVH
`define USPI_DEFS_SVH
`define USPI_MODE_W 4
`define USPI_MODE_MASTER 4'hE
`define USPI_MODE_SLAVE 4'hF
`define USPI_DATA_W 8
`define USPI_CNT_W 4
`define USPI_DIV_DEF 16'h0004
`define USPI_MODE_NONE 4'h0
`define USPI_LAST_BIT 4'h7
`define USPI_SLAVE_LAST 3'h7
`endif

// ---- pkg/uspi_pkg.sv ----
// types for the transceiver spi-mode link
// assumes uspi_defs.svh is compiled alongside
package uspi_pkg;
	typedef enum logic [2:0]
	{
		USPI_IDLE = 3'h1,
		USPI_SHIFT = 3'h2,
		USPI_DONE = 3'h4
	} uspi_state_e;
	// one transfer word and its request flag
	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} uspi_word_s;
endpackage : uspi_pkg

// ---- verification/uspi_far_slave.sv ----
// far spi slave, echoes last byte
// assumes clock idles low
`timescale 1ns/1ps
module uspi_far_slave (
	input wire logic sel_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	output logic miso_out
);
	logic [7:0] sr_reg = 8'hA5;
	// shift on rising clock; deselected it shows the inverse
	always @(posedge sck_in) sr_reg <= {sr_reg[6:0], mosi_in};
	assign miso_out = sel_in ? sr_reg[7] : ~sr_reg[7];
endmodule : uspi_far_slave

// ---- verification/uspi_link_props.sv ----
// pin checks for the link
// assumes divider of four or more
`timescale 1ns/1ps
module uspi_link_props (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic tx_valid_in,
	input wire logic tx_ready_out,
	input wire logic rx_valid_out,
	input wire logic txd_oe_out,
	input wire logic clk_out,
	input wire logic clk_oe_out,
	input wire logic rts_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// frame framing against the user handshake
	a_start_select: assert property (tx_valid_in && tx_ready_out |-> ##[1:3] rts_out)
		else $error("no select");
	a_busy_select: assert property (rts_out |-> !tx_ready_out) else $error("ready");
	a_clk_idle: assert property (!rts_out |-> !clk_out) else $error("idle clk");
	a_clk_start: assert property ($rose(rts_out) |-> !clk_out) else $error("clk");
	a_clk_hold: assert property ($rose(clk_out) |=> clk_out) else $error("clk hi");
	a_clk_drive: assert property (rts_out |-> clk_oe_out) else $error("clk oe");
	a_mosi_drive: assert property (rts_out |-> txd_oe_out) else $error("txd oe");
	a_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out) else $error("rx");
endmodule : uspi_link_props

// ---- verification/uspi_link_tb.sv ----
// bench: master bytes, then one slave byte
// assumes model and checker compiled first
`timescale 1ns/1ps
module uspi_link_tb;
	logic mclk_in = 0, rst_n_in = 0, soft_reset_in = 0, tx_valid_in = 0, link_clk_in = 0;
	logic cts_in = 0, sl = 0, d = 0, miso, rxd_in, tx_ready_out, rx_valid_out, txd_out;
	logic txd_oe_out, clk_out, clk_oe_out, rts_out;
	logic [3:0] channel_operating_select_in = 4'hE;
	logic [7:0] tx_data_in = 8'hA5, rx_data_out, q [$];
	int failures = 0, comparisons = 0, i, j;
	assign rxd_in = sl ? d : miso;
	uspi_link #(.DIV(16'h0004)) uut (.*);
	uspi_far_slave far (.sel_in(rts_out), .sck_in(clk_out), .mosi_in(txd_out), .miso_out(miso));
	initial forever #5 mclk_in = ~mclk_in;
	task automatic chk(input logic [7:0] s, e);
		comparisons++;
		failures += (s !== e);
		if (s !== e)
			$display("MISMATCH rx_data_out exp %h seen %h", e, s);
	endtask : chk
	task automatic close_out;
		$display("cmp %0d fail %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// bounded wait: notes drained and, as master, link idle
	task automatic settle;
		for (i = 0; i < 400 && (q.size() > 0 || !(sl || tx_ready_out === 1'b1)); i++)
			@(posedge mclk_in) #1;
		failures += (i == 400);
		if (i == 400)
			close_out();
	endtask : settle
	task automatic pulse(ref logic p);
		p = 1;
		@(posedge mclk_in) #1;
		p = 0;
	endtask : pulse
	// each result pops the oldest note
	always @(posedge mclk_in)
		if (rx_valid_out === 1'b1)
			chk(rx_data_out, q.pop_front());
	initial
	begin
		void'($urandom(32'h394E));
		repeat (3) @(posedge mclk_in) #1;
		rst_n_in = 1;
		repeat (3) @(posedge mclk_in) #1;
		pulse(soft_reset_in);
		for (j = 0; j < 6; j++)
		begin
			settle();
			q.push_back(tx_data_in);
			tx_data_in = j ? 8'($urandom) : 8'hFF;
			pulse(tx_valid_in);
		end
		settle();
		sl = 1;
		channel_operating_select_in = 4'hF;
		pulse(soft_reset_in);
		cts_in = 1;
		tx_data_in = 8'($urandom);
		q.push_back(tx_data_in);
		for (j = 7; j >= 0; j--)
		begin
			d = tx_data_in[j];
			#40 link_clk_in = 1;
			#40 link_clk_in = 0;
		end
		cts_in = 0;
		d = ~d;
		settle();
		close_out();
	end
endmodule : uspi_link_tb
bind uspi_link uspi_link_props props (.*);
